/* rtl/qpfrc_regs.svh */
`ifndef QPFRC_REGS_SVH
`define QPFRC_REGS_SVH

// timebase
`define QPFRC_CLK_PERIOD_NS 10
`define QPFRC_TICK_NS 100000

// fixed delays, microseconds
`define QPFRC_RELAY_ON_DELAY_US 25600
`define QPFRC_RELAY_OFF_DELAY_US 3200
`define QPFRC_OPEN_DELAY_US 25600
`define QPFRC_QUALIFY_DELAY_US 900000

// time limit per resistor step of 2 kohm, microseconds
`define QPFRC_TLIMIT_STEP_US 6400
`define QPFRC_RES_CODE_OPEN 5'h00
`define QPFRC_RES_CODE_DEFAULT 5'h01
`define QPFRC_RES_CODE_MAX 5'h14

// retry off-time as multiples of the time limit
`define QPFRC_RETRY_MULT_LOW 7'h63
`define QPFRC_RETRY_MULT_HIGH 7'h31
`define QPFRC_RETRY_MULT_OPEN 7'h18

// three-level select encoding
`define QPFRC_RATIO_LOW 2'h0
`define QPFRC_RATIO_HIGH 2'h1

`endif

/* rtl/qpfrc_pkg.sv */
package qpfrc_pkg;

    typedef enum logic [1:0] {
        QPFRC_OFF = 2'b00,
        QPFRC_ON = 2'b01,
        QPFRC_FAULT = 2'b11
    } qpfrc_state_t;

    typedef struct packed {
        qpfrc_state_t st;
        logic armed;
        logic ol_flag;
        logic relay_req_d;
        logic relay_en;
        logic relay_ready;
        logic [8:0] relay_cnt;
        logic [10:0] oc_cnt;
        logic [13:0] qual_cnt;
        logic qualified;
        logic [8:0] low_cnt;
        logic waiting;
        logic [10:0] wait_tick;
        logic [6:0] wait_rep;
        logic sw_en;
        logic status;
    } qpfrc_port_t;

    typedef struct packed {
        logic [13:0] tick_cnt;
        logic tick;
        logic fault_n;
        qpfrc_port_t [3:0] port;
    } qpfrc_state_all_t;

endpackage

/* rtl/qpfrc_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module qpfrc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // meta_r feeds only the second stage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

`default_nettype wire

/* rtl/qpfrc_top.sv */
// What this block does
// RQ1: overcurrent time limit scales linearly with resistor code, 6.4ms to 128ms.
// RQ2: unconnected timing resistor gives the 6.4ms default time limit.
// RQ3: current limit beyond the time limit latches switch off, power good low, fault.
// RQ4: auto-restart keeps a current-limit latched port off for the wait time, then restarts, repeatedly; open-load latches wait for a clear.
// RQ5: wait time is 99, 49 or 24 time limits for low, high, open select.
// RQ6: without auto-restart the port stays latched off with fault low until cleared.
// RQ7: on request low clears latch and fault; switch restarts only on a new request.
// RQ8: after a latch-off the switch stays off at least the wait time.
// RQ9: switch turns on only while the port relay is enabled.
// RQ10: shared fault output low whenever any port is latched off.
// RQ11: open-load detect enable turns low-current detection on or off for all ports.
// RQ12: status shows power good when view select high, open-load flag when low.
// RQ13: power good only when switch voltage good, not limiting, not open-circuit.
// RQ14: with detection on, low current for 25.6ms latches off, faults, flags open-load.
// RQ15: on request low clears an open-load latch, its fault and its flag.
// RQ16: open-load view is high only when latched off for low current and enabled.
// RQ17: supply lockout drives fault low and turns all switches and relays off.
// RQ18: relay request rise enables relay at once, switch delayed 25.6ms.
// RQ19: relay request fall turns switch off at once, relay off 3.2ms later.
// RQ20: low-current detection is armed 900ms after switch on with power good met.
// RQ21: delays counted as whole ticks of the timebase; all pins synchronised first.
// RQ22: leaving lockout, ports start off and cleared, needing a fresh on request.
`timescale 1ns/1ns
`default_nettype none
`include "qpfrc_regs.svh"

module qpfrc_top #(
    parameter int TICK_CYCLES = `QPFRC_TICK_NS / `QPFRC_CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] port_on_request,
    input wire logic [3:0] port_relay_request,
    input wire logic [3:0] port_over_current,
    input wire logic [3:0] port_low_current,
    input wire logic [3:0] port_switch_volts_ok,
    input wire logic open_load_detect_enable,
    input wire logic auto_restart_enable,
    input wire logic [1:0] retry_ratio_select,
    input wire logic status_view_select,
    input wire logic supply_ok,
    input wire logic [4:0] timing_resistor,
    output logic [3:0] port_switch_enable,
    output logic [3:0] relay_drive_out,
    output logic [3:0] port_status,
    output logic fault_n
);

    localparam int TICK_US = `QPFRC_TICK_NS / 1000;
    localparam logic [8:0] RELAY_ON_TICKS = 9'(`QPFRC_RELAY_ON_DELAY_US / TICK_US);
    localparam logic [8:0] RELAY_OFF_TICKS = 9'(`QPFRC_RELAY_OFF_DELAY_US / TICK_US);
    localparam logic [8:0] OPEN_TICKS = 9'(`QPFRC_OPEN_DELAY_US / TICK_US);
    localparam logic [13:0] QUAL_TICKS = 14'(`QPFRC_QUALIFY_DELAY_US / TICK_US);
    localparam logic [10:0] TLIMIT_STEP = 11'(`QPFRC_TLIMIT_STEP_US / TICK_US);
    localparam logic [13:0] TICK_LAST = 14'(TICK_CYCLES - 1);

    logic [30:0] sync_bus;
    logic [3:0] on_s;
    logic [3:0] relay_s;
    logic [3:0] oc_s;
    logic [3:0] low_s;
    logic [3:0] volts_s;
    logic ole_s;
    logic are_s;
    logic [1:0] ratio_s;
    logic view_s;
    logic supply_s;
    logic [4:0] res_s;
    logic [10:0] tlimit;
    logic [6:0] retry_mult;

    qpfrc_pkg::qpfrc_state_all_t cur_r;
    qpfrc_pkg::qpfrc_state_all_t cur_nxt;

    // pins come from outside the clock domain
    qpfrc_sync #(
        .WIDTH(31)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({port_on_request, port_relay_request, port_over_current, port_low_current,
                   port_switch_volts_ok, open_load_detect_enable, auto_restart_enable,
                   retry_ratio_select, status_view_select, supply_ok, timing_resistor}),
        .sync_out(sync_bus)
    );

    assign {on_s, relay_s, oc_s, low_s, volts_s, ole_s, are_s, ratio_s, view_s, supply_s, res_s} = sync_bus;

    // time limit in ticks from the resistor code; open pin falls back to the default
    function automatic logic [10:0] tlimit_ticks(input logic [4:0] code);
        logic [4:0] c;
        c = code;
        if (code == `QPFRC_RES_CODE_OPEN)
            c = `QPFRC_RES_CODE_DEFAULT;
        else if (code > `QPFRC_RES_CODE_MAX)
            c = `QPFRC_RES_CODE_MAX;
        tlimit_ticks = 11'(c * TLIMIT_STEP);
    endfunction

    function automatic logic [6:0] retry_count(input logic [1:0] sel);
        case (sel)
            `QPFRC_RATIO_LOW: retry_count = `QPFRC_RETRY_MULT_LOW;
            `QPFRC_RATIO_HIGH: retry_count = `QPFRC_RETRY_MULT_HIGH;
            default: retry_count = `QPFRC_RETRY_MULT_OPEN;
        endcase
    endfunction

    // RQ1 resistor scaled limit
    // RQ2 default when unconnected
    assign tlimit = tlimit_ticks(res_s);
    // RQ5 wait multiple select
    assign retry_mult = retry_count(ratio_s);

    always_comb
    begin
        logic any_fault;
        logic pg;
        any_fault = 1'b0;
        pg = 1'b0;
        cur_nxt = cur_r;

        // RQ21 one-tick timebase
        cur_nxt.tick = 1'b0;
        if (cur_r.tick_cnt >= TICK_LAST)
        begin
            cur_nxt.tick_cnt = '0;
            cur_nxt.tick = 1'b1;
        end
        else
            cur_nxt.tick_cnt = cur_r.tick_cnt + 14'h0001;

        for (int i = 0; i < 4; i++)
        begin
            if (!supply_s)
            begin
                // RQ17 lockout clears everything
                // RQ22 armed cleared, fresh request needed
                cur_nxt.port[i] = '0;
            end
            else
            begin
                if (!on_s[i])
                    cur_nxt.port[i].armed = 1'b1;
                cur_nxt.port[i].relay_req_d = relay_s[i];

                // RQ18 relay on at once, switch later
                if (relay_s[i] && !cur_r.port[i].relay_req_d)
                begin
                    cur_nxt.port[i].relay_en = 1'b1;
                    cur_nxt.port[i].relay_ready = 1'b0;
                    cur_nxt.port[i].relay_cnt = RELAY_ON_TICKS;
                end
                // RQ19 switch off now, relay later
                else if (!relay_s[i] && cur_r.port[i].relay_req_d)
                begin
                    cur_nxt.port[i].relay_ready = 1'b0;
                    cur_nxt.port[i].relay_cnt = RELAY_OFF_TICKS;
                end
                else if (cur_r.tick && cur_r.port[i].relay_en)
                begin
                    if (relay_s[i] && !cur_r.port[i].relay_ready)
                    begin
                        if (cur_r.port[i].relay_cnt <= 9'h001)
                            cur_nxt.port[i].relay_ready = 1'b1;
                        else
                            cur_nxt.port[i].relay_cnt = cur_r.port[i].relay_cnt - 9'h001;
                    end
                    else if (!relay_s[i])
                    begin
                        if (cur_r.port[i].relay_cnt <= 9'h001)
                            cur_nxt.port[i].relay_en = 1'b0;
                        else
                            cur_nxt.port[i].relay_cnt = cur_r.port[i].relay_cnt - 9'h001;
                    end
                end

                // RQ8 wait time runs whatever the state
                // RQ4 counted in time-limit periods
                if (cur_r.port[i].waiting && cur_r.tick)
                begin
                    if (cur_r.port[i].wait_tick >= tlimit - 11'h001)
                    begin
                        cur_nxt.port[i].wait_tick = '0;
                        if (cur_r.port[i].wait_rep <= 7'h01)
                            cur_nxt.port[i].waiting = 1'b0;
                        else
                            cur_nxt.port[i].wait_rep = cur_r.port[i].wait_rep - 7'h01;
                    end
                    else
                        cur_nxt.port[i].wait_tick = cur_r.port[i].wait_tick + 11'h001;
                end

                case (cur_r.port[i].st)
                    qpfrc_pkg::QPFRC_OFF:
                    begin
                        // RQ9 relay must be ready
                        // RQ7 fresh request only
                        // RQ8 no start while waiting
                        if (cur_r.port[i].armed && on_s[i] && relay_s[i] && cur_r.port[i].relay_ready &&
                            !cur_r.port[i].waiting)
                        begin
                            cur_nxt.port[i].st = qpfrc_pkg::QPFRC_ON;
                            cur_nxt.port[i].oc_cnt = '0;
                            cur_nxt.port[i].qual_cnt = '0;
                            cur_nxt.port[i].qualified = 1'b0;
                            cur_nxt.port[i].low_cnt = '0;
                        end
                    end
                    qpfrc_pkg::QPFRC_ON:
                    begin
                        if (!on_s[i] || !relay_s[i] || !cur_r.port[i].relay_ready)
                            cur_nxt.port[i].st = qpfrc_pkg::QPFRC_OFF;
                        else
                        begin
                            // RQ3 time in current limit
                            if (!oc_s[i])
                                cur_nxt.port[i].oc_cnt = '0;
                            else if (cur_r.tick)
                                cur_nxt.port[i].oc_cnt = cur_r.port[i].oc_cnt + 11'h001;
                            // RQ20 qualify before detecting
                            if (!volts_s[i] || oc_s[i])
                                cur_nxt.port[i].qual_cnt = '0;
                            else if (cur_r.tick && !cur_r.port[i].qualified)
                            begin
                                cur_nxt.port[i].qual_cnt = cur_r.port[i].qual_cnt + 14'h0001;
                                if (cur_r.port[i].qual_cnt + 14'h0001 >= QUAL_TICKS)
                                    cur_nxt.port[i].qualified = 1'b1;
                            end
                            // RQ11 shared detect enable
                            // RQ14 low current time
                            if (!ole_s || !cur_r.port[i].qualified || !low_s[i])
                                cur_nxt.port[i].low_cnt = '0;
                            else if (cur_r.tick)
                                cur_nxt.port[i].low_cnt = cur_r.port[i].low_cnt + 9'h001;
                            if (cur_r.port[i].oc_cnt >= tlimit || cur_r.port[i].low_cnt >= OPEN_TICKS)
                            begin
                                // RQ3 latch off
                                // RQ14 flag open load
                                cur_nxt.port[i].st = qpfrc_pkg::QPFRC_FAULT;
                                cur_nxt.port[i].ol_flag = cur_r.port[i].oc_cnt < tlimit;
                                cur_nxt.port[i].armed = 1'b0;
                                cur_nxt.port[i].waiting = 1'b1;
                                cur_nxt.port[i].wait_tick = '0;
                                cur_nxt.port[i].wait_rep = retry_mult;
                            end
                        end
                    end
                    qpfrc_pkg::QPFRC_FAULT:
                    begin
                        if (!on_s[i])
                        begin
                            // RQ7 clear on request low
                            // RQ15 clear open load too
                            cur_nxt.port[i].st = qpfrc_pkg::QPFRC_OFF;
                            cur_nxt.port[i].ol_flag = 1'b0;
                        end
                        // RQ4 automatic restart
                        // RQ6 otherwise stays latched
                        else if (are_s && !cur_r.port[i].ol_flag && !cur_r.port[i].waiting &&
                                 relay_s[i] && cur_r.port[i].relay_ready)
                        begin
                            cur_nxt.port[i].st = qpfrc_pkg::QPFRC_ON;
                            cur_nxt.port[i].oc_cnt = '0;
                            cur_nxt.port[i].qual_cnt = '0;
                            cur_nxt.port[i].qualified = 1'b0;
                            cur_nxt.port[i].low_cnt = '0;
                        end
                    end
                    default:
                        cur_nxt.port[i].st = qpfrc_pkg::QPFRC_OFF;
                endcase
            end

            cur_nxt.port[i].sw_en = cur_nxt.port[i].st == qpfrc_pkg::QPFRC_ON;
            if (cur_nxt.port[i].st == qpfrc_pkg::QPFRC_FAULT)
                any_fault = 1'b1;
            // RQ13 power good terms
            pg = cur_nxt.port[i].sw_en && volts_s[i] && !oc_s[i] && !cur_nxt.port[i].ol_flag;
            // RQ12 status view
            // RQ16 open-load view gated by enable
            cur_nxt.port[i].status = view_s ? pg : (cur_nxt.port[i].ol_flag && ole_s);
        end

        // RQ10 shared fault
        // RQ17 fault low in lockout
        cur_nxt.fault_n = supply_s && !any_fault;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cur_r <= '0;
        else
            cur_r <= cur_nxt;
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            port_switch_enable[i] = cur_r.port[i].sw_en;
            relay_drive_out[i] = cur_r.port[i].relay_en;
            port_status[i] = cur_r.port[i].status;
        end
        fault_n = cur_r.fault_n;
    end

    // relations on port 0; every port shares the same logic
    property p_lockout_off;
        @(posedge clk) disable iff (rst)
        !supply_s |=> (cur_r.port[0].sw_en == 1'b0) && !cur_r.port[0].relay_en && !cur_r.fault_n;
    endproperty
    a_lockout_off: assert property (p_lockout_off) else $error("lockout did not clear port"); // RQ17

    property p_fault_low;
        @(posedge clk) disable iff (rst)
        (cur_r.port[0].st == qpfrc_pkg::QPFRC_FAULT) |-> !cur_r.fault_n;
    endproperty
    a_fault_low: assert property (p_fault_low) else $error("fault output high while latched"); // RQ10

    property p_relay_fall;
        @(posedge clk) disable iff (rst)
        (!relay_s[0] && cur_r.port[0].relay_req_d) |=> !cur_r.port[0].sw_en ##1 !cur_r.port[0].sw_en;
    endproperty
    a_relay_fall: assert property (p_relay_fall) else $error("switch stayed on after relay fall"); // RQ19

    property p_relay_rise;
        @(posedge clk) disable iff (rst)
        (supply_s && relay_s[0] && !cur_r.port[0].relay_req_d)
            |=> cur_r.port[0].relay_en && !cur_r.port[0].relay_ready;
    endproperty
    a_relay_rise: assert property (p_relay_rise) else $error("relay not enabled at once"); // RQ18

    property p_on_needs_relay;
        @(posedge clk) disable iff (rst)
        $rose(cur_r.port[0].sw_en) |-> cur_r.port[0].relay_en && $past(cur_r.port[0].relay_ready);
    endproperty
    a_on_needs_relay: assert property (p_on_needs_relay) else $error("switch on without relay"); // RQ9

    property p_latched;
        @(posedge clk) disable iff (rst)
        (cur_r.port[0].st == qpfrc_pkg::QPFRC_FAULT && !are_s && on_s[0] && supply_s)
            |=> cur_r.port[0].st == qpfrc_pkg::QPFRC_FAULT;
    endproperty
    a_latched: assert property (p_latched) else $error("latch released without clear"); // RQ6

    property p_clear;
        @(posedge clk) disable iff (rst)
        (cur_r.port[0].st == qpfrc_pkg::QPFRC_FAULT && !on_s[0])
            |=> cur_r.port[0].st == qpfrc_pkg::QPFRC_OFF && !cur_r.port[0].ol_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("request low did not clear latch"); // RQ7

    property p_hold_off;
        @(posedge clk) disable iff (rst)
        (cur_r.port[0].waiting && cur_r.port[0].st != qpfrc_pkg::QPFRC_ON) |=> !cur_r.port[0].sw_en;
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("restart during wait time"); // RQ8

    property p_open_view;
        @(posedge clk) disable iff (rst)
        (!view_s && !ole_s) |=> !cur_r.port[0].status;
    endproperty
    a_open_view: assert property (p_open_view) else $error("open-load view high while disabled"); // RQ16

endmodule

`default_nettype wire

/* sim/qpfrc_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none

module qpfrc_ctrl_model (
    input wire logic clk,
    output logic [3:0] on_req,
    output logic [3:0] rly_req
);
    initial
    begin
        on_req = 4'h0;
        rly_req = 4'h0;
    end

    task set_on(input int p, input logic v);
        @(posedge clk);
        on_req[p] <= v;
    endtask

    task set_relay(input int p, input logic v);
        @(posedge clk);
        rly_req[p] <= v;
    endtask

    task clear(input int p, input int gap);
        set_on(p, 1'b0);
        repeat (gap) @(posedge clk);
        set_on(p, 1'b1);
    endtask

    task power(input int p, input int w);
        set_relay(p, 1'b1);
        repeat (w) @(posedge clk);
        clear(p, 2);
    endtask
endmodule

`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    // short tick keeps the run small; all figures scale with it
    localparam int TK = 2;
    localparam int LIM = 64 * TK;
    localparam int RON = 256 * TK;
    localparam int ROFF = 32 * TK;
    localparam int QUAL = 9000 * TK;
    localparam int TOL = 3 * TK + 6;
    logic clk;
    logic rst;
    logic [3:0] on_req;
    logic [3:0] rly_req;
    logic [3:0] oc;
    logic [3:0] lc;
    logic [3:0] vok;
    logic ol_en;
    logic ar_en;
    logic [1:0] ratio;
    logic view;
    logic sup_ok;
    logic [4:0] res;
    logic [3:0] sw;
    logic [3:0] rly;
    logic [3:0] stat;
    logic fault_n;
    int bad_count;
    int num_checks;
    int n;
    int w;
    int mults[3] = '{99, 49, 24};
    int codes[3] = '{1, 1, 2};

    qpfrc_ctrl_model ctrl (.clk(clk), .on_req(on_req), .rly_req(rly_req));

    qpfrc_top #(.TICK_CYCLES(TK)) dut (.clk(clk), .rst(rst), .port_on_request(on_req),
        .port_relay_request(rly_req), .port_over_current(oc), .port_low_current(lc),
        .port_switch_volts_ok(vok), .open_load_detect_enable(ol_en), .auto_restart_enable(ar_en),
        .retry_ratio_select(ratio), .status_view_select(view), .supply_ok(sup_ok),
        .timing_resistor(res), .port_switch_enable(sw), .relay_drive_out(rly),
        .port_status(stat), .fault_n(fault_n));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string s, input logic e, input logic v);
        num_checks++;
        if (v !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", s, e, v);
        end
    endtask

    task automatic chk_rng(input string s, input int lo, input int hi, input int v);
        num_checks++;
        if (v < lo || v > hi)
        begin
            bad_count++;
            $display("mismatch %s expected %0d..%0d seen %0d", s, lo, hi, v);
        end
    endtask

    // bounded wait on switch (k=0) or relay (k=1); n counts cycles
    task automatic wait_o(input int k, input int p, input logic v, input int lim);
        n = 0;
        // step off the edge so an output launched there has settled
        #1;
        while (((k == 0) ? sw[p] : rly[p]) !== v && n < lim)
        begin
            cyc(1);
            n++;
        end
    endtask

    // overload on port 0 until the time limit trips; load stays applied
    task automatic trip(input int lim);
        @(posedge clk);
        oc[0] <= 1'b1;
        cyc(4);
        chk("power good in limit", 1'b0, stat[0]);
        wait_o(0, 0, 1'b0, lim + TOL);
        chk_rng("time limit", lim - TOL, lim + TOL, n + 4);
        chk("fault on latch", 1'b0, fault_n);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        bad_count++;
        $display("mismatch watchdog expected done seen hang");
        tally_and_finish();
    end

    initial
    begin
        rst = 1'b1;
        {oc, lc, vok} = 12'h00f;
        {ol_en, ar_en, ratio, view, sup_ok} = 6'h0b;
        res = 5'h00;
        bad_count = 0;
        num_checks = 0;
        cyc(12);
        chk("fault in reset", 1'b0, fault_n);
        @(posedge clk);
        rst <= 1'b0;
        cyc(6);
        chk("fault after reset", 1'b1, fault_n);
        ctrl.set_on(2, 1'b1);
        ctrl.set_relay(0, 1'b1);
        cyc(4);
        chk("relay at once", 1'b1, rly[0]);
        ctrl.clear(0, 2);
        cyc(RON / 2);
        chk("switch early", 1'b0, sw[0]);
        cyc(RON);
        ctrl.clear(0, 2);
        wait_o(0, 0, 1'b1, 10);
        chk("switch on", 1'b1, sw[0]);
        chk("switch without relay", 1'b0, sw[2]);
        cyc(4);
        chk("power good", 1'b1, stat[0]);
        @(posedge clk);
        view <= 1'b0;
        cyc(4);
        chk("open flag view", 1'b0, stat[0]);
        @(posedge clk);
        view <= 1'b1;
        $display("test start done");
        trip(LIM);
        @(posedge clk);
        oc[0] <= 1'b0;
        ctrl.clear(0, 4);
        cyc(4);
        chk("fault cleared", 1'b1, fault_n);
        wait_o(0, 0, 1'b1, 24 * LIM + TOL);
        chk_rng("hold off", 24 * LIM - 2 * TOL, 24 * LIM + TOL, n);
        trip(LIM);
        @(posedge clk);
        oc[0] <= 1'b0;
        cyc(30 * LIM);
        chk("stay latched", 1'b0, sw[0]);
        chk("fault held", 1'b0, fault_n);
        ctrl.clear(0, 4);
        wait_o(0, 0, 1'b1, 20);
        chk("restart on request", 1'b1, sw[0]);
        $display("test latch done");
        @(posedge clk);
        ar_en <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk);
            ratio <= i[1:0];
            res <= codes[i][4:0];
            cyc(4);
            trip(LIM * codes[i]);
            w = mults[i] * LIM * codes[i];
            wait_o(0, 0, 1'b1, w + TOL);
            chk_rng("retry wait", w - TOL, w + TOL, n);
            @(posedge clk);
            oc[0] <= 1'b0;
        end
        @(posedge clk);
        ar_en <= 1'b0;
        res <= 5'h00;
        $display("test retry done");
        ctrl.set_relay(0, 1'b0);
        cyc(4);
        chk("switch at relay drop", 1'b0, sw[0]);
        chk("relay held", 1'b1, rly[0]);
        wait_o(1, 0, 1'b0, ROFF + TOL);
        chk_rng("relay off delay", ROFF - TOL, ROFF + TOL, n + 4);
        $display("test relay_stop done");
        @(posedge clk);
        {ol_en, view, lc[1]} <= 3'h5;
        ctrl.power(1, RON + 8);
        wait_o(0, 1, 1'b1, 10);
        wait_o(0, 1, 1'b0, QUAL + RON + TOL);
        chk_rng("open-load delay", QUAL + RON - TOL, QUAL + RON + TOL, n);
        chk("open-load flag", 1'b1, stat[1]);
        chk("open-load fault", 1'b0, fault_n);
        ctrl.set_on(1, 1'b0);
        cyc(4);
        chk("flag cleared", 1'b0, stat[1]);
        chk("open fault cleared", 1'b1, fault_n);
        @(posedge clk);
        ol_en <= 1'b0;
        ctrl.set_on(1, 1'b1);
        cyc(QUAL + RON + 24 * LIM + 200);
        chk("detect disabled", 1'b1, sw[1]);
        chk("flag when disabled", 1'b0, stat[1]);
        $display("test open_load done");
        @(posedge clk);
        sup_ok <= 1'b0;
        cyc(5);
        chk("lockout fault", 1'b0, fault_n);
        chk("lockout switches", 1'b0, |sw);
        chk("lockout relays", 1'b0, |rly);
        @(posedge clk);
        sup_ok <= 1'b1;
        cyc(RON + 20);
        chk("no restart", 1'b0, |sw);
        chk("fault after lockout", 1'b1, fault_n);
        $display("test lockout done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
